//--- vcl_cfg.svh
`ifndef VCL_CFG_SVH
`define VCL_CFG_SVH

// ****************************************
// register word offsets (byte addresses)
// ****************************************
`define VCL_A_CMD 8'h00
`define VCL_A_OPLO 8'h04
`define VCL_A_OPHI 8'h08
`define VCL_A_FIDX 8'h0C
`define VCL_A_FDATA 8'h10
`define VCL_A_STATUS 8'h14
`define VCL_A_WPLO 8'h18
`define VCL_A_WPHI 8'h1C
`define VCL_A_CPLO 8'h20
`define VCL_A_CPHI 8'h24
`define VCL_A_PPLO 8'h28
`define VCL_A_PPHI 8'h2C

// ****************************************
// command codes written to the command word
// ****************************************
`define VCL_OP_CLEAR 3'h1
`define VCL_OP_PTRLD 3'h2
`define VCL_OP_LAUNCH 3'h3
`define VCL_OP_RESUME 3'h4
`define VCL_OP_FWRITE 3'h5
`define VCL_OP_FREAD 3'h6

// ****************************************
// status bit positions
// ****************************************
`define VCL_ST_BUSY 0
`define VCL_ST_INVF 1
`define VCL_ST_VALF 2
`define VCL_ST_RUN 3
`define VCL_ST_LAUNCHED 4

// ****************************************
// field indices inside the structure image
// ****************************************
`define VCL_F_EXITCTL 4'h0
`define VCL_F_ENTRYCTL 4'h1
`define VCL_F_EXECCTL 4'h2
`define VCL_F_HOSTTR 4'h3
`define VCL_F_EXCBMP 4'h4
`define VCL_F_PFMASK 4'h5
`define VCL_F_PFMATCH 4'h6
`define VCL_F_REASON 4'h7
`define VCL_F_QUAL 4'h8
`define VCL_F_INSTERR 4'h9
`define VCL_F_LASTCHK 4'h6

// ****************************************
// pointers, codes and reasons
// ****************************************
`define VCL_PTR_INVALID 64'hFFFF_FFFF_FFFF_FFFF
`define VCL_PAGE_SHIFT 12
`define VCL_ERR_LAUNCH 32'h0000_0004
`define VCL_ERR_RESUME 32'h0000_0005
`define VCL_ERR_CTL 32'h0000_0007
`define VCL_ERR_HOST 32'h0000_0008
`define VCL_RSN_EXC 32'h0000_0000
`define VCL_RSN_BADGUEST 32'h8000_0021
`define VCL_RSN_FAIL_BIT 31
`define VCL_VEC_PF 5'h0E

`endif

//--- vcl_field_mem.sv
`timescale 1ns/10ps
`default_nettype none

// single-port-write, registered-read image of the structure fields
module vcl_field_mem #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [W-1:0] wData,
  input wire logic [AW-1:0] rAddr,
  output logic [W-1:0] rData
);

  // storage has no reset; the clear walk gives it defined contents
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rData_ff;

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  // read data always from a register, one cycle after the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rData_ff <= '0;
    end else begin
      rData_ff <= mem[rAddr];
    end
  end

  assign rData = rData_ff;

endmodule

`default_nettype wire

//--- vcl_lifecycle.sv
`timescale 1ns/10ps
`default_nettype none
`include "vcl_cfg.svh"

module vcl_lifecycle
  import vcl_pkg::*;
#(
  parameter int NUM_SLOTS = 4,
  parameter int NUM_FIELDS = 16,
  parameter logic [31:0] EXIT_A0 = 32'h0000_0000,
  parameter logic [31:0] EXIT_A1 = 32'hFFFF_FFFF,
  parameter logic [31:0] ENTRY_A0 = 32'h0000_0000,
  parameter logic [31:0] ENTRY_A1 = 32'hFFFF_FFFF,
  parameter logic [31:0] EXEC_A0 = 32'h0000_0000,
  parameter logic [31:0] EXEC_A1 = 32'hFFFF_FFFF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic guestExcValid,
  input wire logic [4:0] guestExcVector,
  input wire logic [31:0] guestExcErrCode,
  input wire logic [31:0] guestFaultAddr,
  input wire logic guestExitReq,
  input wire logic [15:0] guestExitReason,
  input wire logic guestStateBad,
  output logic guestRunning,
  output logic hostStateLoad,
  output logic invPtrFailFlag,
  output logic validPtrFailFlag
);

  localparam int SB = $clog2(NUM_SLOTS);
  localparam int FB = $clog2(NUM_FIELDS);

  // ****************************************
  // parameter checks
  // ****************************************
  // slot index is a plain bit slice of the pointer, so the slot count must be a power of two
  if (NUM_SLOTS < 2 || NUM_FIELDS < 16 || (NUM_SLOTS & (NUM_SLOTS - 1)) != 0) begin : g_chk
    $error("vcl_lifecycle: needs a power-of-two slot count of at least 2 and 16 fields");
  end

  // ****************************************
  // state
  // ****************************************
  vcl_state_t state_ff, nxt_state;
  logic [63:0] wPtr_ff; // working pointer
  logic [63:0] cPtr_ff; // controlling pointer
  logic [63:0] pPtr_ff; // parent pointer
  logic [63:0] opnd_ff; // command operand
  logic [FB-1:0] fIdx_ff; // field index for access commands
  logic [31:0] fData_ff; // field write data
  logic [31:0] fRd_ff; // field read result
  logic invF_ff, validF_ff; // instruction outcome flags
  logic run_ff, hostLd_ff;
  logic [NUM_SLOTS-1:0] launched_ff; // launch state per region slot
  logic [FB-1:0] walk_ff; // clear walk and check walk index
  logic [31:0] bmp_ff, pfMask_ff, pfMatch_ff; // shadows used while guest runs
  logic [31:0] rsn_ff, qual_ff, err_ff; // pending field writes
  logic isLaunch_ff; // entry came from first-entry command
  logic [31:0] rdData_ff;

  // ****************************************
  // decode
  // ****************************************
  wire idle = (state_ff == S_IDLE);
  wire busy = !idle && (state_ff != S_RUN);
  // config writes only while idle so an op in flight keeps its operands
  wire cfgWr = regWrEn && idle;
  wire cmdGo = cfgWr && (regAddr == `VCL_A_CMD);
  wire [2:0] op = regWrData[2:0];
  wire opClear = cmdGo && (op == `VCL_OP_CLEAR);
  wire opPtrld = cmdGo && (op == `VCL_OP_PTRLD);
  wire opLaunch = cmdGo && (op == `VCL_OP_LAUNCH);
  wire opResume = cmdGo && (op == `VCL_OP_RESUME);
  wire opFwr = cmdGo && (op == `VCL_OP_FWRITE);
  wire opFrd = cmdGo && (op == `VCL_OP_FREAD);
  wire opEntry = opLaunch || opResume;
  wire needPtr = opEntry || opFwr || opFrd;
  wire wValid = (wPtr_ff != `VCL_PTR_INVALID);
  // slots index whole pages; relies on software aligning regions
  wire [SB-1:0] wSlot = wPtr_ff[`VCL_PAGE_SHIFT +: SB];
  wire [SB-1:0] oSlot = opnd_ff[`VCL_PAGE_SHIFT +: SB];
  wire wLaunched = launched_ff[wSlot];
  wire ptrFail = needPtr && !wValid;
  wire stateFail = wValid && ((opLaunch && wLaunched) || (opResume && !wLaunched));
  wire walkLast = (walk_ff == FB'(NUM_FIELDS - 1));
  wire chkLast = (walk_ff == FB'(`VCL_F_LASTCHK));
  wire launchOk = (state_ff == S_LOAD) && !guestStateBad && isLaunch_ff;

  // ****************************************
  // field image
  // ****************************************
  wire [31:0] memRd;
  wire memWe = (state_ff == S_CLR) || (state_ff == S_FWR) || (state_ff == S_ERR) ||
               (state_ff == S_XRSN) || (state_ff == S_XQUAL);
  wire [FB-1:0] memWa = (state_ff == S_CLR) ? walk_ff :
                        (state_ff == S_FWR) ? fIdx_ff :
                        (state_ff == S_ERR) ? FB'(`VCL_F_INSTERR) :
                        (state_ff == S_XRSN) ? FB'(`VCL_F_REASON) : FB'(`VCL_F_QUAL);
  wire [31:0] memWd = (state_ff == S_CLR) ? 32'h0000_0000 :
                      (state_ff == S_FWR) ? fData_ff :
                      (state_ff == S_ERR) ? err_ff :
                      (state_ff == S_XRSN) ? rsn_ff : qual_ff;
  wire [FB-1:0] memRa = (state_ff == S_CHKRD) ? walk_ff : fIdx_ff;

  vcl_field_mem #(.W(32), .DEPTH(NUM_FIELDS)) u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(memWe),
    .wAddr(memWa),
    .wData(memWd),
    .rAddr(memRa),
    .rData(memRd)
  );

  // ****************************************
  // entry checks
  // ****************************************
  wire [31:0] a0Sel = (walk_ff == FB'(`VCL_F_EXITCTL)) ? EXIT_A0 :
                      (walk_ff == FB'(`VCL_F_ENTRYCTL)) ? ENTRY_A0 : EXEC_A0;
  wire [31:0] a1Sel = (walk_ff == FB'(`VCL_F_EXITCTL)) ? EXIT_A1 :
                      (walk_ff == FB'(`VCL_F_ENTRYCTL)) ? ENTRY_A1 : EXEC_A1;
  wire isCtl = (walk_ff < FB'(`VCL_F_HOSTTR));
  wire isTaskSel = (walk_ff == FB'(`VCL_F_HOSTTR));
  wire ctlBad = isCtl && !vcl_ctl_ok(memRd, a0Sel, a1Sel);
  // table and privilege bits zero, null selector cannot name a task segment
  wire taskSelBad = isTaskSel && ((memRd[2:0] != 3'h0) || (memRd[15:3] == 13'h0000));
  wire chkBad = (state_ff == S_CHKEV) && (ctlBad || taskSelBad);

  // ****************************************
  // guest exit decision
  // ****************************************
  wire pfHit = ((guestExcErrCode & pfMask_ff) == pfMatch_ff);
  wire isPf = (guestExcVector == `VCL_VEC_PF);
  // page faults exit when match agrees with bitmap bit
  wire excExit = guestExcValid && (isPf ? (bmp_ff[`VCL_VEC_PF] == pfHit) : bmp_ff[guestExcVector]);
  wire anyExit = (state_ff == S_RUN) && (excExit || guestExitReq);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (opClear) begin
          nxt_state = S_CLR;
        end else if (ptrFail) begin
          nxt_state = S_IDLE; // only the invalid-pointer flag reports it
        end else if (stateFail) begin
          nxt_state = S_ERR;
        end else if (opEntry) begin
          nxt_state = S_CHKRD;
        end else if (opFwr) begin
          nxt_state = S_FWR;
        end else if (opFrd) begin
          nxt_state = S_FRD;
        end
      end
      S_CLR: nxt_state = walkLast ? S_IDLE : S_CLR;
      S_FWR: nxt_state = S_IDLE;
      S_FRD: nxt_state = S_FRW;
      S_FRW: nxt_state = S_IDLE;
      S_CHKRD: nxt_state = S_CHKEV;
      S_CHKEV: begin
        if (chkBad) begin
          nxt_state = S_ERR;
        end else begin
          nxt_state = chkLast ? S_LOAD : S_CHKRD;
        end
      end
      S_LOAD: nxt_state = guestStateBad ? S_XRSN : S_RUN;
      S_RUN: nxt_state = anyExit ? S_XRSN : S_RUN;
      S_ERR: nxt_state = S_IDLE;
      S_XRSN: nxt_state = S_XQUAL;
      S_XQUAL: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // state register, running level and single-cycle host reload pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= S_IDLE;
      run_ff <= 1'b0;
      hostLd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      run_ff <= (nxt_state == S_RUN);
      hostLd_ff <= (state_ff == S_XQUAL); // host state restored, no guest save
    end
  end

  // ****************************************
  // pointers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wPtr_ff <= `VCL_PTR_INVALID;
      cPtr_ff <= `VCL_PTR_INVALID;
      pPtr_ff <= `VCL_PTR_INVALID;
    end else begin
      if (opClear) begin
        wPtr_ff <= `VCL_PTR_INVALID;
      end else if (opPtrld) begin
        wPtr_ff <= opnd_ff;
      end
      if (launchOk) begin
        cPtr_ff <= wPtr_ff;
        pPtr_ff <= cPtr_ff;
      end
    end
  end

  // launch state per slot
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        launched_ff[i] <= 1'b0;
      end else if (opClear && (oSlot == SB'(i))) begin
        launched_ff[i] <= 1'b0;
      end else if (launchOk && (wSlot == SB'(i))) begin
        launched_ff[i] <= 1'b1;
      end
    end
  end

  // ****************************************
  // operands and walk index
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opnd_ff <= 64'h0000_0000_0000_0000;
      fIdx_ff <= '0;
      fData_ff <= 32'h0000_0000;
      walk_ff <= '0;
      isLaunch_ff <= 1'b0;
    end else begin
      if (cfgWr && regAddr == `VCL_A_OPLO) opnd_ff[31:0] <= regWrData;
      if (cfgWr && regAddr == `VCL_A_OPHI) opnd_ff[63:32] <= regWrData;
      if (cfgWr && regAddr == `VCL_A_FIDX) fIdx_ff <= regWrData[FB-1:0];
      if (cfgWr && regAddr == `VCL_A_FDATA) fData_ff <= regWrData;
      if (opEntry) isLaunch_ff <= opLaunch;
      // walk restarts on each command; steps on each clear write or check
      if (cmdGo) begin
        walk_ff <= '0;
      end else if (state_ff == S_CLR || state_ff == S_CHKEV) begin
        walk_ff <= walk_ff + FB'(1);
      end
    end
  end

  // ****************************************
  // outcome flags and pending field values
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      invF_ff <= 1'b0;
      validF_ff <= 1'b0;
      err_ff <= 32'h0000_0000;
    end else if (cmdGo) begin
      // a new command wipes the old outcome, then reports its own
      invF_ff <= ptrFail;
      validF_ff <= !ptrFail && stateFail;
      err_ff <= opLaunch ? `VCL_ERR_LAUNCH : `VCL_ERR_RESUME;
    end else if (chkBad) begin
      validF_ff <= 1'b1;
      err_ff <= ctlBad ? `VCL_ERR_CTL : `VCL_ERR_HOST;
    end
  end

  // exit record, captured shadows and field-read result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsn_ff <= 32'h0000_0000;
      qual_ff <= 32'h0000_0000;
      bmp_ff <= 32'h0000_0000;
      pfMask_ff <= 32'h0000_0000;
      pfMatch_ff <= 32'h0000_0000;
      fRd_ff <= 32'h0000_0000;
    end else begin
      if (state_ff == S_LOAD && guestStateBad) begin
        rsn_ff <= `VCL_RSN_BADGUEST;
        qual_ff <= 32'h0000_0000;
      end else if (anyExit) begin
        rsn_ff <= excExit ? `VCL_RSN_EXC : {16'h0000, guestExitReason};
        qual_ff <= (excExit && isPf) ? guestFaultAddr : 32'h0000_0000;
      end
      if (state_ff == S_CHKEV && walk_ff == FB'(`VCL_F_EXCBMP)) bmp_ff <= memRd;
      if (state_ff == S_CHKEV && walk_ff == FB'(`VCL_F_PFMASK)) pfMask_ff <= memRd;
      if (state_ff == S_CHKEV && walk_ff == FB'(`VCL_F_PFMATCH)) pfMatch_ff <= memRd;
      if (state_ff == S_FRW) fRd_ff <= memRd;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  wire [31:0] status = {27'h0000000, wValid && wLaunched, run_ff, validF_ff, invF_ff, busy};
  wire [31:0] rdMux = (regAddr == `VCL_A_OPLO) ? opnd_ff[31:0] :
                      (regAddr == `VCL_A_OPHI) ? opnd_ff[63:32] :
                      (regAddr == `VCL_A_FIDX) ? 32'(fIdx_ff) :
                      (regAddr == `VCL_A_FDATA) ? fRd_ff :
                      (regAddr == `VCL_A_STATUS) ? status :
                      (regAddr == `VCL_A_WPLO) ? wPtr_ff[31:0] :
                      (regAddr == `VCL_A_WPHI) ? wPtr_ff[63:32] :
                      (regAddr == `VCL_A_CPLO) ? cPtr_ff[31:0] :
                      (regAddr == `VCL_A_CPHI) ? cPtr_ff[63:32] :
                      (regAddr == `VCL_A_PPLO) ? pPtr_ff[31:0] :
                      (regAddr == `VCL_A_PPHI) ? pPtr_ff[63:32] : 32'h0000_0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= 32'h0000_0000;
    end else begin
      rdData_ff <= regRdEn ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdData = rdData_ff;
  assign guestRunning = run_ff;
  assign hostStateLoad = hostLd_ff;
  assign invPtrFailFlag = invF_ff;
  assign validPtrFailFlag = validF_ff;

  // ****************************************
  // checks
  // ****************************************
  a_clear_invalidates: assert property (@(posedge clk) disable iff (!rst_b)
    opClear |=> (wPtr_ff == `VCL_PTR_INVALID) ##1 (state_ff == S_CLR))
    else $error("clear did not invalidate working pointer");
  a_clear_slot: assert property (@(posedge clk) disable iff (!rst_b)
    opClear |=> !launched_ff[$past(oSlot)])
    else $error("clear did not mark slot clear");
  a_ptr_load: assert property (@(posedge clk) disable iff (!rst_b)
    opPtrld |=> (wPtr_ff == $past(opnd_ff)))
    else $error("pointer load took wrong value");
  a_launch_ptrs: assert property (@(posedge clk) disable iff (!rst_b)
    launchOk |=> (cPtr_ff == $past(wPtr_ff)) && (pPtr_ff == $past(cPtr_ff)))
    else $error("launch pointer copy wrong");
  a_launch_state: assert property (@(posedge clk) disable iff (!rst_b)
    launchOk |=> launched_ff[$past(wSlot)] && run_ff)
    else $error("launch did not mark launched");
  a_inv_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdGo && ptrFail) |=> invF_ff && !validF_ff && idle)
    else $error("invalid pointer failure not flagged");
  a_state_fail: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdGo && !ptrFail && stateFail) |=> validF_ff && memWe &&
      (memWa == FB'(`VCL_F_INSTERR)) ##1 idle)
    else $error("wrong launch state not failed");
  a_check_fail: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == S_CHKEV && ctlBad) |=> validF_ff && (err_ff == `VCL_ERR_CTL))
    else $error("control check failure not reported");
  a_entry_fail: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == S_LOAD && guestStateBad) |=> rsn_ff[`VCL_RSN_FAIL_BIT] ##2 hostLd_ff)
    else $error("guest state failure not reported");
  a_exc_exit: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == S_RUN && guestExcValid && !isPf && bmp_ff[guestExcVector]) |=>
      (state_ff == S_XRSN) && !run_ff)
    else $error("bitmap exception did not exit");
  a_pf_qual: assert property (@(posedge clk) disable iff (!rst_b)
    (anyExit && excExit && isPf) |=> ##1 memWe && (memWa == FB'(`VCL_F_QUAL)) &&
      (memWd == $past(guestFaultAddr, 2)))
    else $error("page fault address not recorded");

endmodule

`default_nettype wire

//--- vcl_lifecycle_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "vcl_cfg.svh"

module vcl_lifecycle_tb
  import vcl_pkg::*;
;
  // ****************************************
  // stimulus signals, all valued at time zero
  // ****************************************
  localparam logic [63:0] ALLONES = `VCL_PTR_INVALID;
  localparam logic [31:0] REV_ID = 32'h0000_5A3C; // revision word, value arbitrary
  logic clk = 1'h0;
  logic rst_b = 1'h0; // low from time zero
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'h0;
  logic regRdEn = 1'h0;
  logic [31:0] regRdData;
  logic guestExcValid = 1'h0;
  logic [4:0] guestExcVector = 5'h00;
  logic [31:0] guestExcErrCode = 32'h0;
  logic [31:0] guestFaultAddr = 32'h0;
  logic guestExitReq = 1'h0;
  logic [15:0] guestExitReason = 16'h0;
  logic guestStateBad = 1'h0;
  logic guestRunning, hostStateLoad, invPtrFailFlag, validPtrFailFlag;
  int errCount = 0;
  int checksDone = 0;
  int hslCount = 0; // host reload pulses seen
  logic [31:0] rnd = 32'hF337; // lfsr state, fixed seed
  logic [31:0] s, bmp, msk, mat, err;
  logic [63:0] v64, pA, pB;
  logic [4:0] vec;
  logic ex;
  int n;

  always #2.5 clk = ~clk;

  // exec control bit 0 forced to one, so a zero word must be refused
  vcl_lifecycle #(.EXEC_A0(32'h0000_0001)) u_dut (.clk(clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .guestExcValid(guestExcValid), .guestExcVector(guestExcVector),
    .guestExcErrCode(guestExcErrCode), .guestFaultAddr(guestFaultAddr),
    .guestExitReq(guestExitReq), .guestExitReason(guestExitReason),
    .guestStateBad(guestStateBad), .guestRunning(guestRunning),
    .hostStateLoad(hostStateLoad), .invPtrFailFlag(invPtrFailFlag),
    .validPtrFailFlag(validPtrFailFlag));

  // the pulse lasts one cycle, so count it rather than poll for it
  always @(posedge clk) if (hostStateLoad === 1'b1) hslCount++;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction

  // page faults also compare the masked error code
  function automatic logic exitExp(input logic [4:0] v, input logic [31:0] e);
    if (v == `VCL_VEC_PF) return bmp[14] == ((e & msk) == mat);
    return bmp[v];
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errCount == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one-cycle strobes; a gap edge keeps each signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge clk);
    regWrEn <= 1'h0;
  endtask

  // data stands only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge clk);
    regRdEn <= 1'h0;
    #1 d = regRdData;
  endtask

  task automatic rptr(input logic [7:0] a, output logic [63:0] v);
    logic [31:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    v = {hi, lo};
  endtask

  // bounded poll of the busy bit; running out counts as a failure
  task automatic cmd(input logic [2:0] op, input logic [63:0] opnd);
    logic [31:0] st;
    wr(`VCL_A_OPLO, opnd[31:0]);
    wr(`VCL_A_OPHI, opnd[63:32]);
    wr(`VCL_A_CMD, {29'h0, op});
    st = 32'h1;
    for (int i = 0; i < 64 && st[`VCL_ST_BUSY] !== 1'b0; i++) rd(`VCL_A_STATUS, st);
    if (st[`VCL_ST_BUSY] !== 1'b0) errCount++;
  endtask

  task automatic fwr(input logic [3:0] idx, input logic [31:0] val);
    wr(`VCL_A_FIDX, {28'h0, idx});
    wr(`VCL_A_FDATA, val);
    cmd(`VCL_OP_FWRITE, 64'h0);
  endtask

  task automatic fchk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wr(`VCL_A_FIDX, {28'h0, idx});
    cmd(`VCL_OP_FREAD, 64'h0);
    rd(`VCL_A_FDATA, v);
    chk("field", {28'h0, idx, v}, {28'h0, idx, exp});
  endtask

  task automatic chkf(input logic i, input logic v);
    chk("fail flags", {invPtrFailFlag, validPtrFailFlag}, {i, v});
  endtask

  // one guest event, then room for the exit to finish
  task automatic ev(input logic isExc, input logic [4:0] v, input logic [31:0] e,
                    input logic [31:0] fa, input logic [15:0] r);
    @(posedge clk);
    guestExcValid <= isExc;
    guestExitReq <= ~isExc;
    guestExcVector <= v;
    guestExcErrCode <= e;
    guestFaultAddr <= fa;
    guestExitReason <= r;
    @(posedge clk);
    guestExcValid <= 1'h0;
    guestExitReq <= 1'h0;
    repeat (6) @(posedge clk);
  endtask

  // ****************************************
  // watchdog: generous against about a thousand cycles of work
  // ****************************************
  initial begin
    #200000;
    errCount++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    rptr(`VCL_A_WPLO, v64);
    chk("working ptr at reset", v64, ALLONES);
    rd(8'hFC, s);
    chk("unmapped read", s, 32'h0);
    cmd(`VCL_OP_FWRITE, 64'h0);
    chkf(1'b1, 1'b0);
    // page-aligned regions in slots 1 and 2
    rnd = lfsr(rnd);
    pA = {32'h0, rnd[31:14], 2'h1, 12'h000};
    pB = {32'h0, rnd[31:14], 2'h2, 12'h000};
    cmd(`VCL_OP_CLEAR, pA);
    chkf(1'b0, 1'b0);
    rptr(`VCL_A_WPLO, v64);
    chk("working ptr after clear", v64, ALLONES);
    cmd(`VCL_OP_PTRLD, pA);
    rptr(`VCL_A_WPLO, v64);
    chk("working ptr after load", v64, pA);
    // software stamps the revision word first; the image keeps it in a spare field
    fwr(4'hA, REV_ID);
    fchk(4'hA, REV_ID);
    fchk(`VCL_F_EXCBMP, 32'h0);
    // controls first with a refused exec word, then a bad task selector
    fwr(`VCL_F_EXITCTL, 32'h0);
    fwr(`VCL_F_ENTRYCTL, 32'h0);
    fwr(`VCL_F_EXECCTL, 32'h0);
    fwr(`VCL_F_HOSTTR, 32'h0000_0009);
    cmd(`VCL_OP_LAUNCH, 64'h0);
    chkf(1'b0, 1'b1);
    fchk(`VCL_F_INSTERR, `VCL_ERR_CTL);
    fwr(`VCL_F_EXECCTL, 32'h0000_0001);
    cmd(`VCL_OP_LAUNCH, 64'h0);
    chkf(1'b0, 1'b1);
    fchk(`VCL_F_INSTERR, `VCL_ERR_HOST);
    fwr(`VCL_F_HOSTTR, 32'h0000_0008);
    cmd(`VCL_OP_RESUME, 64'h0);
    chkf(1'b0, 1'b1);
    fchk(`VCL_F_INSTERR, `VCL_ERR_RESUME);
    // bad guest state falls back to the host area, launch state untouched
    n = hslCount;
    @(posedge clk);
    guestStateBad <= 1'h1;
    cmd(`VCL_OP_LAUNCH, 64'h0);
    @(posedge clk);
    guestStateBad <= 1'h0;
    chk("host reload", hslCount - n, 1);
    fchk(`VCL_F_REASON, `VCL_RSN_BADGUEST);
    rd(`VCL_A_STATUS, s);
    chk("launched after bad guest", s[`VCL_ST_LAUNCHED], 1'h0);
    // random bitmap with vector 6 off and the page-fault bit on
    rnd = lfsr(rnd);
    bmp = (rnd | 32'h0000_4000) & ~32'h0000_0040;
    rnd = lfsr(rnd);
    msk = rnd | 32'h1;
    rnd = lfsr(rnd);
    mat = rnd & msk;
    fwr(`VCL_F_EXCBMP, bmp);
    fwr(`VCL_F_PFMASK, msk);
    fwr(`VCL_F_PFMATCH, mat);
    cmd(`VCL_OP_LAUNCH, 64'h0);
    chk("running", guestRunning, 1'h1);
    rd(`VCL_A_STATUS, s);
    chk("launched", s[`VCL_ST_LAUNCHED], 1'h1);
    rptr(`VCL_A_CPLO, v64);
    chk("controlling ptr", v64, pA);
    rptr(`VCL_A_PPLO, v64);
    chk("parent ptr", v64, ALLONES);
    // corner cases first: masked vector, page-fault mismatch, page-fault match
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr(rnd);
      vec = (i == 0) ? 5'h06 : (i < 3) ? `VCL_VEC_PF : rnd[4:0];
      err = (i == 1) ? (mat ^ msk) : (i == 2 || rnd[5]) ? mat : rnd;
      ex = exitExp(vec, err);
      n = hslCount;
      ev(1'b1, vec, err, ~rnd, 16'h0);
      chk("exit on exception", guestRunning, !ex);
      if (ex) begin
        chk("exit reload", hslCount - n, 1);
        fchk(`VCL_F_REASON, `VCL_RSN_EXC);
        if (vec == `VCL_VEC_PF) fchk(`VCL_F_QUAL, ~rnd);
        cmd(`VCL_OP_RESUME, 64'h0);
        chkf(1'b0, 1'b0);
      end
    end
    // other programmed exit condition with a random reason
    rnd = lfsr(rnd);
    if (guestRunning !== 1'b1) cmd(`VCL_OP_RESUME, 64'h0);
    ev(1'b0, 5'h00, 32'h0, 32'h0, rnd[15:0]);
    chk("exit on request", guestRunning, 1'h0);
    fchk(`VCL_F_REASON, {16'h0, rnd[15:0]});
    cmd(`VCL_OP_LAUNCH, 64'h0);
    chkf(1'b0, 1'b1);
    fchk(`VCL_F_INSTERR, `VCL_ERR_LAUNCH);
    // second structure: old controlling pointer becomes the parent
    cmd(`VCL_OP_PTRLD, pB);
    cmd(`VCL_OP_LAUNCH, 64'h0);
    chk("running second", guestRunning, 1'h1);
    ev(1'b0, 5'h00, 32'h0, 32'h0, 16'h0001);
    rptr(`VCL_A_CPLO, v64);
    chk("controlling ptr second", v64, pB);
    rptr(`VCL_A_PPLO, v64);
    chk("parent ptr second", v64, pA);
    conclude();
  end

endmodule

`default_nettype wire

//--- vcl_pkg.sv
package vcl_pkg;

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_CLR, S_FWR, S_FRD, S_FRW, S_CHKRD, S_CHKEV,
    S_LOAD, S_RUN, S_ERR, S_XRSN, S_XQUAL
  } vcl_state_t;

  // control word honours the forced-one and allowed-one masks
  function automatic logic vcl_ctl_ok(input logic [31:0] v, input logic [31:0] a0,
                                      input logic [31:0] a1);
    return ((v & a0) == a0) && ((v & ~a1) == 32'h0000_0000);
  endfunction

endpackage
